// >>> logic/mds_pkg.sv
package mds_pkg;
  // Divider and pointer geometry
  localparam int CLK_DIV_WIDTH = 4;
  localparam int FIFO_DEPTH = 8;
  localparam int FIFO_PTR_WIDTH = 3;
  localparam int FB_DIV_WIDTH = 6;
  localparam logic [FB_DIV_WIDTH-1:0] FB_DIV_DEFAULT = 6'h10;
  // Coarse gain code and scale
  localparam int GAIN_WIDTH = 4;
  localparam int GAIN_SCALE = 16;
  localparam logic [GAIN_WIDTH-1:0] GAIN_RESET = 4'hF;
  // Reset values of control bits
  localparam logic DIV_ALIGN_RESET = 1'b0;
  localparam logic FB_ALIGN_RESET = 1'b0;
  localparam logic EXT_REF_RESET = 1'b0;
  // Sync state machine
  typedef enum logic [1:0] {
    MDS_IDLE,
    MDS_ARMED,
    MDS_ALIGNED
  } mds_state_type;
endpackage

// >>> logic/mds_fb_divider.sv
`timescale 1ns/10ps
// Feedback divider; produces a one-cycle strobe every div_in cycles
module mds_fb_divider #(
  parameter int WIDTH = 6
) (
  input wire logic mclk_in,
  input wire logic rst_in,
  input wire logic [WIDTH-1:0] div_in,
  input wire logic realign_in,
  output logic strobe_out
);
  logic [WIDTH-1:0] count_reg;
  logic [WIDTH-1:0] count_next;
  logic wrap;

  initial begin
    if (WIDTH < 2) begin
      $error("mds_fb_divider: WIDTH must be at least 2");
    end
  end

  // Wrap at div_in-1; a zero divide acts as divide by one
  assign wrap = (count_reg >= div_in - WIDTH'(1)) || (div_in == '0);
  assign count_next = wrap ? '0 : count_reg + WIDTH'(1);

  // Realign forces a known phase
  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      count_reg <= '0;
      strobe_out <= 1'b0;
    end else if (realign_in) begin
      count_reg <= '0;
      strobe_out <= 1'b0;
    end else begin
      count_reg <= count_next;
      strobe_out <= wrap;
    end
  end
endmodule

// >>> logic/mds_sync_ctrl.sv
`timescale 1ns/10ps
// Summary of operation
// - Dual sync sources mode needs an output strobe on top of the data interface to align.
// - FIFO reads start at the same converter clock edge in every synchronized device.
// - The output strobe input is sampled by the converter clock.
// - With PLL on, the strobe is generated internally from the reference clock.
// - A sync rising edge resets the feedback dividers while PLL and feedback alignment are both enabled.
// - In PLL mode sync and input strobe, and the two clocks, have no fixed relation.
// - A 4-bit coarse gain code scales full-scale current by (code+1)/16.
// - Internal bandgap is on while external reference select is 0, external used when 1.
module mds_sync_ctrl #(
  parameter int CLK_DIV_WIDTH = mds_pkg::CLK_DIV_WIDTH,
  parameter int FIFO_PTR_WIDTH = mds_pkg::FIFO_PTR_WIDTH,
  parameter int FB_DIV_WIDTH = mds_pkg::FB_DIV_WIDTH
) (
  input wire logic mclk_in,
  input wire logic rst_in,
  input wire logic output_strobe_in,
  input wire logic sync_in,
  input wire logic input_strobe_in,
  input wire logic dual_sync_mode_in,
  input wire logic pll_enable_in,
  input wire logic div_align_enable_in,
  input wire logic fb_align_enable_in,
  input wire logic [CLK_DIV_WIDTH-1:0] clk_div_in,
  input wire logic [FB_DIV_WIDTH-1:0] fb_div_in,
  input wire logic [mds_pkg::GAIN_WIDTH-1:0] coarse_gain_in,
  input wire logic ext_ref_select_in,
  output logic [CLK_DIV_WIDTH-1:0] clk_div_phase_out,
  output logic clk_div_tick_out,
  output logic [FIFO_PTR_WIDTH-1:0] fifo_rd_ptr_out,
  output logic align_event_out,
  output logic fb_reset_event_out,
  output logic aligned_out,
  output logic [mds_pkg::GAIN_WIDTH:0] gain_numerator_out,
  output logic internal_ref_on_out,
  output logic ext_ref_used_out
);
  // Synchronisers for pins from outside the converter clock domain
  logic output_strobe_meta_reg;
  logic output_strobe_sync_reg;
  logic output_strobe_prev_reg;
  logic sync_meta_reg;
  logic sync_sync_reg;
  logic sync_prev_reg;
  logic input_strobe_meta_reg;
  logic input_strobe_sync_reg;
  logic [CLK_DIV_WIDTH-1:0] div_reg;
  logic [CLK_DIV_WIDTH-1:0] div_next;
  logic [FIFO_PTR_WIDTH-1:0] rd_ptr_reg;
  logic [FIFO_PTR_WIDTH-1:0] rd_ptr_next;
  logic [mds_pkg::GAIN_WIDTH:0] gain_reg;
  logic int_ref_reg;
  logic ext_ref_reg;
  logic align_reg;
  logic fb_evt_reg;
  mds_pkg::mds_state_type state_reg;
  mds_pkg::mds_state_type state_next;
  logic output_strobe_rise;
  logic sync_rise;
  logic internal_strobe;
  logic strobe_sel;
  logic align_now;
  logic fb_realign;
  logic div_wrap;

  initial begin
    if (FIFO_PTR_WIDTH < 1 || CLK_DIV_WIDTH < 1 || FB_DIV_WIDTH < 2) begin
      $error("mds_sync_ctrl: widths out of range");
    end
  end

  // Two-stage capture; first stage feeds only the second
  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      output_strobe_meta_reg <= 1'b0;
      output_strobe_sync_reg <= 1'b0;
      sync_meta_reg <= 1'b0;
      sync_sync_reg <= 1'b0;
      input_strobe_meta_reg <= 1'b0;
      input_strobe_sync_reg <= 1'b0;
    end else begin
      output_strobe_meta_reg <= output_strobe_in;
      output_strobe_sync_reg <= output_strobe_meta_reg;
      sync_meta_reg <= sync_in;
      sync_sync_reg <= sync_meta_reg;
      input_strobe_meta_reg <= input_strobe_in;
      input_strobe_sync_reg <= input_strobe_meta_reg;
    end
  end

  // Edge history taken from the second stage only
  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      output_strobe_prev_reg <= 1'b0;
      sync_prev_reg <= 1'b0;
    end else begin
      output_strobe_prev_reg <= output_strobe_sync_reg;
      sync_prev_reg <= sync_sync_reg;
    end
  end

  assign output_strobe_rise = output_strobe_sync_reg & ~output_strobe_prev_reg;
  assign sync_rise = sync_sync_reg & ~sync_prev_reg;

  // Feedback divider reset on sync edge only while enabled
  assign fb_realign = pll_enable_in & fb_align_enable_in & sync_rise;

  mds_fb_divider #(
    .WIDTH(FB_DIV_WIDTH)
  ) u_fb_div (
    .mclk_in(mclk_in),
    .rst_in(rst_in),
    .div_in(fb_div_in),
    .realign_in(fb_realign),
    .strobe_out(internal_strobe)
  );

  // PLL mode uses the internal strobe, otherwise the pin
  // Input strobe plays no part in alignment timing here
  assign strobe_sel = pll_enable_in ? internal_strobe : output_strobe_rise;

  // Alignment only in dual sync mode with the strobe present
  assign align_now = dual_sync_mode_in & div_align_enable_in & strobe_sel;

  // Clock divider and read pointer both restart on the shared strobe
  assign div_wrap = (div_reg >= clk_div_in) || (clk_div_in == '0);
  assign div_next = align_now ? '0 : (div_wrap ? '0 : div_reg + CLK_DIV_WIDTH'(1));
  assign rd_ptr_next = align_now ? '0
                     : (div_wrap ? rd_ptr_reg + FIFO_PTR_WIDTH'(1) : rd_ptr_reg);

  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      div_reg <= '0;
      rd_ptr_reg <= '0;
      align_reg <= 1'b0;
      fb_evt_reg <= 1'b0;
    end else begin
      div_reg <= div_next;
      rd_ptr_reg <= rd_ptr_next;
      align_reg <= align_now;
      fb_evt_reg <= fb_realign;
    end
  end

  // Alignment status; cleared when dual sync mode is dropped
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      mds_pkg::MDS_IDLE: begin
        // A strobe in the first enabled cycle still counts as aligned
        if (align_now) begin
          state_next = mds_pkg::MDS_ALIGNED;
        end else if (div_align_enable_in && dual_sync_mode_in) begin
          state_next = mds_pkg::MDS_ARMED;
        end
      end
      mds_pkg::MDS_ARMED: begin
        if (!div_align_enable_in || !dual_sync_mode_in) begin
          state_next = mds_pkg::MDS_IDLE;
        end else if (align_now) begin
          state_next = mds_pkg::MDS_ALIGNED;
        end
      end
      mds_pkg::MDS_ALIGNED: begin
        // Disabling the enable keeps alignment
        if (!dual_sync_mode_in) begin
          state_next = mds_pkg::MDS_IDLE;
        end
      end
      default: begin
        state_next = mds_pkg::MDS_IDLE;
      end
    endcase
  end

  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      state_reg <= mds_pkg::MDS_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  // Gain numerator is code plus one over a fixed 16
  // Reference select registered to avoid glitches on the analog bias
  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      gain_reg <= {1'b0, mds_pkg::GAIN_RESET} + 5'h01;
      int_ref_reg <= ~mds_pkg::EXT_REF_RESET;
      ext_ref_reg <= mds_pkg::EXT_REF_RESET;
    end else begin
      gain_reg <= {1'b0, coarse_gain_in} + 5'h01;
      int_ref_reg <= ~ext_ref_select_in;
      ext_ref_reg <= ext_ref_select_in;
    end
  end

  assign clk_div_phase_out = div_reg;
  assign clk_div_tick_out = div_wrap;
  assign fifo_rd_ptr_out = rd_ptr_reg;
  assign align_event_out = align_reg;
  assign fb_reset_event_out = fb_evt_reg;
  assign aligned_out = (state_reg == mds_pkg::MDS_ALIGNED);
  assign gain_numerator_out = gain_reg;
  assign internal_ref_on_out = int_ref_reg;
  assign ext_ref_used_out = ext_ref_reg;
endmodule

// >>> tb/mds_sync_checker.sv
`timescale 1ns/10ps
// Ties alignment, feedback reset, gain and reference outputs to their causes
module mds_sync_checker #(
  parameter int CLK_DIV_WIDTH = 4,
  parameter int FIFO_PTR_WIDTH = 3
) (
  input wire logic mclk_in,
  rst_in,
  output_strobe_in,
  sync_in,
  dual_sync_mode_in,
  pll_enable_in,
  div_align_enable_in,
  fb_align_enable_in,
  ext_ref_select_in,
  align_event_out,
  fb_reset_event_out,
  aligned_out,
  internal_ref_on_out,
  ext_ref_used_out,
  input wire logic [mds_pkg::GAIN_WIDTH-1:0] coarse_gain_in,
  input wire logic [mds_pkg::GAIN_WIDTH:0] gain_numerator_out,
  input wire logic [CLK_DIV_WIDTH-1:0] clk_div_phase_out,
  input wire logic [FIFO_PTR_WIDTH-1:0] fifo_rd_ptr_out
);
  default clocking @(posedge mclk_in);
  endclocking
  default disable iff (rst_in);
  // Pin edges only count while the mode bits allow them
  sequence output_strobe_taken;
    $rose(output_strobe_in) && dual_sync_mode_in && div_align_enable_in && !pll_enable_in;
  endsequence
  sequence sync_taken;
    $rose(sync_in) && pll_enable_in && fb_align_enable_in;
  endsequence
  chk_strobe_align: assert property (output_strobe_taken |-> ##[2:4] align_event_out)
    else $error("strobe edge without alignment");
  chk_align_cause: assert property (align_event_out |->
    $past(dual_sync_mode_in) && $past(div_align_enable_in)) else $error("alignment uncalled");
  chk_align_zero: assert property (align_event_out |-> aligned_out &&
    clk_div_phase_out == '0 && fifo_rd_ptr_out == '0) else $error("pointers not cleared");
  chk_fb_reset: assert property (sync_taken |-> ##[2:4] fb_reset_event_out)
    else $error("sync edge without divider reset");
  chk_fb_cause: assert property (fb_reset_event_out |->
    $past(pll_enable_in) && $past(fb_align_enable_in)) else $error("divider reset uncalled");
  chk_gain_value: assert property (!$past(rst_in) && $stable(coarse_gain_in) |->
    gain_numerator_out == coarse_gain_in + 5'h01) else $error("gain numerator wrong");
  chk_ref_select: assert property (!$past(rst_in) && $stable(ext_ref_select_in) |->
    internal_ref_on_out != ext_ref_select_in && ext_ref_used_out == ext_ref_select_in)
    else $error("reference select wrong");
  chk_aligned_drop: assert property (!dual_sync_mode_in [*2] |-> !aligned_out)
    else $error("aligned outside dual mode");
endmodule
bind mds_sync_ctrl mds_sync_checker #(.CLK_DIV_WIDTH(CLK_DIV_WIDTH),
  .FIFO_PTR_WIDTH(FIFO_PTR_WIDTH)) mds_sync_checker_inst (.*);

// >>> tb/mds_sync_src.sv
`timescale 1ns/10ps
// Clock source and host: each request gives a 4-cycle pulse
module mds_sync_src (
  input wire logic mclk_in,
  input wire logic output_strobe_req_in,
  input wire logic sync_req_in,
  output logic output_strobe_out,
  output logic sync_out
);
  logic [3:0] output_strobe_reg = 4'h0;
  logic [3:0] sync_reg = 4'h0;
  // Launched off the converter clock, so both share one domain
  always @(negedge mclk_in) begin
    output_strobe_reg <= {output_strobe_reg[2:0], output_strobe_req_in};
    sync_reg <= {sync_reg[2:0], sync_req_in};
  end
  // Lines idle low between pulses
  assign output_strobe_out = |output_strobe_reg;
  assign sync_out = |sync_reg;
endmodule

// >>> tb/tb_top.sv
`timescale 1ns/10ps
module tb_top;
  logic clk = 0, rst = 1, output_strobe, sync, oreq = 0, sreq = 0, input_strobe = 0, hit;
  logic dual = 0, pll = 0, dal = 0, fbal = 0, xref = 0, tick, al_ev, fb_ev, algn, iref, xu;
  logic [3:0] cdiv = 4'h5, gain = 4'h0, ph;
  logic [5:0] fdiv = 6'h10;
  logic [2:0] ptr;
  logic [4:0] gnum;
  int error_cnt = 0, n_tests = 0;
  // Converter clock, 4 ns
  initial forever #2 clk = ~clk;
  mds_sync_src mds_sync_src_inst (.mclk_in(clk), .output_strobe_req_in(oreq), .sync_req_in(sreq),
    .output_strobe_out(output_strobe), .sync_out(sync));
  mds_sync_ctrl mds_sync_ctrl_inst (.mclk_in(clk), .rst_in(rst), .output_strobe_in(output_strobe),
    .sync_in(sync), .input_strobe_in(input_strobe), .dual_sync_mode_in(dual), .pll_enable_in(pll),
    .div_align_enable_in(dal), .fb_align_enable_in(fbal), .clk_div_in(cdiv),
    .fb_div_in(fdiv), .coarse_gain_in(gain), .ext_ref_select_in(xref),
    .clk_div_phase_out(ph), .clk_div_tick_out(tick), .fifo_rd_ptr_out(ptr),
    .align_event_out(al_ev), .fb_reset_event_out(fb_ev), .aligned_out(algn),
    .gain_numerator_out(gnum), .internal_ref_on_out(iref), .ext_ref_used_out(xu));
  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp) begin
      error_cnt++;
      $display("unexpected at %0t: got %h exp %h", $time, got, exp);
    end
  endtask
  // One request to the far side; bounded wait for an event
  task automatic pulse(input bit s);
    if (s) sreq <= 1; else oreq <= 1;
    cyc(1);
    sreq <= 0;
    oreq <= 0;
  endtask
  task automatic wait_ev(input bit fb, input int n);
    hit = 0;
    for (int i = 0; i < n && !hit; i++) begin
      cyc(1);
      hit = fb ? fb_ev === 1'b1 : al_ev === 1'b1;
    end
  endtask
  task automatic final_report;
    $display("checks %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic t_gain;
    for (int c = 0; c < 16; c++) begin
      gain <= c[3:0];
      xref <= c[0];
      cyc(2);
      cmp({gnum, iref, xu, 1'b0}, {5'(c + 1), ~c[0], c[0], 1'b0});
    end
    $display("test gain done");
  endtask
  task automatic t_align;
    dual <= 1;
    dal <= 1;
    cyc(2);
    pulse(0);
    wait_ev(0, 10);
    cmp(hit, 1);
    cyc(5);
    cmp({ph, tick, ptr}, 8'h58);
    cyc(1);
    cmp({ph, tick, ptr}, 8'h01);
    dal <= 0;
    cyc(2);
    cmp(algn, 1);
    pulse(0);
    wait_ev(0, 10);
    cmp(hit, 0);
    $display("test align done");
  endtask
  task automatic t_refuse;
    dal <= 1;
    dual <= 0;
    cyc(2);
    pulse(0);
    wait_ev(0, 10);
    cmp({hit, algn}, 0);
    pulse(1);
    wait_ev(1, 10);
    cmp(hit, 0);
    $display("test refuse done");
  endtask
  task automatic t_pll;
    {pll, fbal, dual, dal, input_strobe} <= 5'h1D;
    cyc(2);
    pulse(1);
    wait_ev(1, 10);
    cmp(hit, 1);
    fbal <= 0;
    cyc(2);
    pulse(1);
    wait_ev(1, 10);
    cmp(hit, 0);
    dal <= 1;
    wait_ev(0, 40);
    cmp(hit, 1);
    $display("test pll done");
  endtask
  initial begin
    cyc(4);
    cmp({gnum, iref, xu, algn}, 8'h84);
    cyc(8);
    rst <= 0;
    cyc(2);
    t_gain();
    t_align();
    t_refuse();
    t_pll();
    final_report();
  end
endmodule
